// ---- core/mux_dram_pkg.sv ----
// Shared constants, types and address mapping for the multiplexed-address link
package mux_dram_pkg;
	// Command pins {select_n, write_n, refresh_n}
	typedef enum logic [2:0] {CMD_MRS = 3'h0, CMD_WRITE = 3'h1, CMD_AUTO_REFRESH_CMD = 3'h2,
		CMD_READ = 3'h3, CMD_NOP = 3'h7} cmd_t;
	typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_REFRESH = 2'h2,
		OP_MODE = 2'h3} op_t;
	typedef enum logic [1:0] {ORG_X36 = 2'h0, ORG_X18 = 2'h1, ORG_X9 = 2'h2} org_t;
	localparam logic [1:0] BL_2 = 2'h0;
	localparam logic [1:0] BL_4 = 2'h1;
	localparam logic [1:0] BL_8 = 2'h2;
	// Mode word fields
	localparam int MODE_BL_LSB = 3;
	localparam int MODE_MUX_BIT = 5;
	localparam int MODE_DLL_RST_BIT = 7;
	localparam logic [9:0] MODE_RESET = 10'h000;
	// Balls that carry their own bit in the first phase
	localparam logic [18:0] PHASE_ONE_MASK = 19'h66739;
	// Configurations 1..5 are codes 0..4
	localparam logic [2:0] CFG_ONE = 3'h0;
	localparam logic [2:0] CFG_FOUR = 3'h3;
	localparam logic [2:0] CFG_LAST = 3'h4;
	localparam logic [3:0] TRC_CLK [0:4] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
	localparam logic [3:0] RL_CLK [0:4] = '{4'h5, 4'h7, 4'h9, 4'h4, 4'h6};
	localparam logic [3:0] WL_CLK [0:4] = '{4'h6, 4'h8, 4'hA, 4'h5, 4'h7};
	localparam int MAX_MHZ [0:4] = '{266, 400, 533, 200, 333};
	localparam int MIN_MHZ = 175;
	localparam logic [3:0] WR_RD_TRC_CFG4 = 4'h4;
	localparam logic [3:0] NONMUX_LAT_DROP = 4'h1;
	// Sequencing counts
	localparam logic [10:0] MRSC_CYC = 11'h006;
	localparam logic [10:0] INIT_DUMMY_MRS = 11'h002;
	localparam logic [10:0] INIT_NOP_CNT = 11'h400;
	localparam logic [2:0] LAST_BANK = 3'h7;
	// Register map of the controller
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_CMD = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int CTRL_START_BIT = 0;
	localparam int ST_DROP_BIT = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic uses_a19(input logic [1:0] org, input logic [1:0] bl);
		return !((org == ORG_X36 && bl != BL_2) || (org == ORG_X18 && bl == BL_8));
	endfunction : uses_a19

	function automatic logic uses_a20(input logic [1:0] org, input logic [1:0] bl);
		return (org == ORG_X18 && bl == BL_2) || (org == ORG_X9 && bl != BL_8);
	endfunction : uses_a20

	function automatic logic drops_a18(input logic [1:0] org, input logic [1:0] bl);
		return org == ORG_X36 && bl == BL_8;
	endfunction : drops_a18

	// First address phase: listed balls carry their own bit
	function automatic logic [18:0] phase_one(input logic [21:0] a, input logic [1:0] org,
		input logic [1:0] bl);
		logic [18:0] p;
		p = a[18:0] & PHASE_ONE_MASK;
		p[18] = p[18] & !drops_a18(org, bl);
		return p;
	endfunction : phase_one

	// Second address phase: the remaining bits folded onto the same balls
	function automatic logic [18:0] phase_two(input logic [21:0] a, input logic [1:0] org,
		input logic [1:0] bl);
		logic [18:0] p;
		p = '0;
		p[3] = a[1];
		p[4] = a[2];
		p[8] = a[6];
		p[9] = a[7];
		p[13] = a[11];
		p[14] = a[12];
		p[17] = a[16];
		p[18] = a[15];
		p[10] = a[19] & uses_a19(org, bl);
		p[0] = a[20] & uses_a20(org, bl);
		p[5] = a[21] & (org == ORG_X9 && bl == BL_2);
		return p;
	endfunction : phase_two

	// Rebuild the full address from both phases
	function automatic logic [21:0] assemble(input logic [18:0] p1, input logic [18:0] p2,
		input logic [1:0] org, input logic [1:0] bl);
		logic [21:0] a;
		a = {3'h0, p1 & PHASE_ONE_MASK};
		a[1] = p2[3];
		a[2] = p2[4];
		a[6] = p2[8];
		a[7] = p2[9];
		a[11] = p2[13];
		a[12] = p2[14];
		a[16] = p2[17];
		a[15] = p2[18];
		a[18] = p1[18] & !drops_a18(org, bl);
		a[19] = p2[10] & uses_a19(org, bl);
		a[20] = p2[0] & uses_a20(org, bl);
		a[21] = p2[5] & (org == ORG_X9 && bl == BL_2);
		return a;
	endfunction : assemble
endpackage : mux_dram_pkg

// ---- core/mux_dram_if.sv ----
// Command and address pins between controller and memory
interface mux_dram_if;
	logic [2:0] cmd_n;
	logic [18:0] addr;
	logic [2:0] bank;
	modport ctrl (output cmd_n, output addr, output bank);
	modport dev (input cmd_n, input addr, input bank);
endinterface : mux_dram_if

// ---- core/mux_dram_dev.sv ----
// Memory end: two-phase command capture, mode register and latency selection
module mux_dram_dev
	import mux_dram_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	mux_dram_if.dev bus,
	input wire logic [1:0] org,
	output logic exec_valid,
	output logic [1:0] exec_op,
	output logic [2:0] exec_bank,
	output logic [21:0] exec_addr,
	output logic mux_mode,
	output logic dll_on,
	output logic [9:0] mode_word,
	output logic [3:0] row_cycle_time,
	output logic [3:0] read_latency,
	output logic [3:0] write_latency
);
	logic held;
	logic [2:0] held_cmd;
	logic [2:0] held_bank;
	logic [18:0] held_ph1;
	logic selected;
	logic take_new;
	logic [9:0] mux_word;
	logic [2:0] cfg_idx;
	logic [1:0] org_meta;
	logic [1:0] org_sync;

	// Width strap comes from a pin; two flops before any logic reads it
	always_ff @(posedge aclk)
	begin
		org_meta <= org;
		org_sync <= org_meta;
	end

	function automatic logic [1:0] op_of(input logic [2:0] c);
		if (c == CMD_WRITE)
			return OP_WRITE;
		else if (c == CMD_AUTO_REFRESH_CMD)
			return OP_REFRESH;
		else
			return OP_READ;
	endfunction : op_of

	// Pins in a second-phase cycle are address only, except after a refresh
	assign selected = !bus.cmd_n[2];
	assign take_new = !held || held_cmd == CMD_AUTO_REFRESH_CMD;
	// Second-phase ball 8 is dropped for mode setting; bank pins unused
	assign mux_word = {held_ph1[9:8], bus.addr[9], 1'b0, held_ph1[5:3], bus.addr[4],
		bus.addr[3], held_ph1[0]};
	assign cfg_idx = (mode_word[2:0] > CFG_LAST) ? CFG_ONE : mode_word[2:0];

	// First phase capture in multiplexed operation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			held <= 1'b0;
			held_cmd <= CMD_NOP;
			held_bank <= 3'h0;
			held_ph1 <= 19'h0;
		end
		else if (mux_mode && take_new && selected)
		begin
			held <= 1'b1;
			held_cmd <= bus.cmd_n;
			held_bank <= bus.bank;
			held_ph1 <= bus.addr;
		end
		else
			held <= 1'b0;
	end

	// Execution one edge after issue in multiplexed operation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			exec_valid <= 1'b0;
			exec_op <= OP_READ;
			exec_bank <= 3'h0;
			exec_addr <= 22'h0;
		end
		else if (held && held_cmd != CMD_MRS)
		begin
			exec_valid <= 1'b1;
			exec_op <= op_of(held_cmd);
			exec_bank <= held_bank;
			exec_addr <= assemble(held_ph1, bus.addr, org_sync,
				mode_word[MODE_BL_LSB+:2]);
		end
		else if (!mux_mode && selected && bus.cmd_n != CMD_MRS)
		begin
			exec_valid <= 1'b1;
			exec_op <= op_of(bus.cmd_n);
			exec_bank <= bus.bank;
			exec_addr <= {3'h0, bus.addr};
		end
		else
			exec_valid <= 1'b0;
	end

	// Mode register; a word without the mux bit is not taken once multiplexed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_word <= MODE_RESET;
			mux_mode <= 1'b0;
			dll_on <= 1'b0;
		end
		else if (held && held_cmd == CMD_MRS && held_ph1[MODE_MUX_BIT])
		begin
			mode_word <= mux_word;
			dll_on <= !mux_word[MODE_DLL_RST_BIT];
		end
		else if (!mux_mode && selected && bus.cmd_n == CMD_MRS)
		begin
			mode_word <= bus.addr[9:0];
			dll_on <= !bus.addr[MODE_DLL_RST_BIT];
			mux_mode <= bus.addr[MODE_MUX_BIT];
		end
	end

	// Latencies from the configuration; one extra clock when multiplexed
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			row_cycle_time <= TRC_CLK[0];
			read_latency <= RL_CLK[0];
			write_latency <= WL_CLK[0];
		end
		else
		begin
			row_cycle_time <= TRC_CLK[cfg_idx];
			read_latency <= mux_mode ? RL_CLK[cfg_idx]
				: RL_CLK[cfg_idx] - NONMUX_LAT_DROP;
			write_latency <= mux_mode ? WL_CLK[cfg_idx]
				: WL_CLK[cfg_idx] - NONMUX_LAT_DROP;
		end
	end
endmodule : mux_dram_dev

// ---- core/mux_dram_ctrl.sv ----
// Controller end: AXI4-Lite registers, init sequence, two-phase command issue
// Functional notes
// - init starts with two dummy MODE_REGISTER_SET_CMD plus one
// - A5 high MODE_REGISTER_SET_CMD enters multiplexed mode
// - multiplexed mode may be entered later too
// - wait mode set recovery before multiplexed MODE_REGISTER_SET_CMD
// - A0,A3,A4,A5,A8,A9 prescribed in multiplexed MODE_REGISTER_SET_CMD
// - A10 to A18 zero during mode set
// - device ignores phase-two bit eight, bank
// - DLL reset field turns DLL off
// - reset DLL when clock or supply change
// - init ends with eight refreshes, 1024 idles
// - row cycle time after refresh, same bank
// - second phase folds A1..A16 onto balls
// - width and burst bits A19..A21, A18
// - multiplexed mode adds one latency clock
// - five configurations of cycle and latencies
// - no burst of eight in configs 1,4
// - config 4 write then read needs 4
// - command executes one edge after issue
// - next command may follow a refresh immediately
// - same bank again only after row cycle
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
module mux_dram_ctrl
	import mux_dram_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	mux_dram_if.ctrl bus,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [3:0] {ST_RESET = 4'h0, ST_DUMMY = 4'h1, ST_WAIT_A = 4'h2,
		ST_MRS_PH1 = 4'h3, ST_MRS_PH2 = 4'h4, ST_WAIT_B = 4'h5, ST_REFRESH = 4'h6,
		ST_NOPS = 4'h7, ST_READY = 4'h8, ST_PHASE2 = 4'h9} state_t;
	state_t state;
	logic aw_got, w_got, pending, dropped, start_init, in_init, init_done;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic [7:0] ctrl;
	logic [21:0] addr_reg;
	logic [1:0] pend_op;
	logic [2:0] pend_bank, ref_bank, prog_cfg, cfg_idx;
	logic [10:0] cnt;
	logic [18:0] ph2_q;
	logic [3:0] trc_left [0:7];
	logic [7:0] wr_extra;
	logic [1:0] bl_eff;
	logic cfg_seen, dll_rst, wr_fire, bank_ok, launch, issue_fire, issue_write;
	logic [2:0] issue_bank;
	logic [9:0] mode_val;

	// Burst of eight is never programmed here; it falls back to four
	assign bl_eff = (ctrl[4:3] >= BL_8) ? BL_4 : ctrl[4:3];
	// A new configuration means a new clock period, so the DLL is reset
	assign dll_rst = !in_init && cfg_seen && ctrl[7:5] != prog_cfg;
	assign mode_val = {2'h0, dll_rst, 1'b0, 1'b1, bl_eff, ctrl[7:5]};
	assign cfg_idx = (prog_cfg > CFG_LAST) ? CFG_ONE : prog_cfg;
	assign wr_fire = aw_got && w_got;
	assign bank_ok = trc_left[pend_bank] == 4'h0 || (trc_left[pend_bank] == 4'h1
		&& wr_extra[pend_bank] && pend_op != OP_READ);
	assign launch = state == ST_READY && pending && (pend_op == OP_MODE || bank_ok);
	assign issue_fire = (launch && pend_op != OP_MODE) || state == ST_REFRESH;
	assign issue_bank = (state == ST_REFRESH) ? ref_bank : pend_bank;
	assign issue_write = launch && pend_op == OP_WRITE;

	// AXI4-Lite channel handshakes; response one edge after both halves are in
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end
		else
		begin
			s_axi_awready <= !aw_got && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_got && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q == REG_CTRL || aw_addr_q == REG_ADDR
					|| aw_addr_q == REG_CMD || aw_addr_q == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel; data sampled at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				if (s_axi_araddr == REG_CTRL)
					s_axi_rdata <= {24'h0, ctrl};
				else if (s_axi_araddr == REG_ADDR)
					s_axi_rdata <= {10'h0, addr_reg};
				else if (s_axi_araddr == REG_CMD)
					s_axi_rdata <= {25'h0, pend_bank, 2'h0, pend_op};
				else if (s_axi_araddr == REG_STATUS)
					s_axi_rdata <= {29'h0, dropped, init_done, state != ST_READY || pending};
				else
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Software registers; a command written while one is pending is dropped
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= CTRL_RESET;
			addr_reg <= 22'h0;
			pending <= 1'b0;
			pend_op <= OP_READ;
			pend_bank <= 3'h0;
			dropped <= 1'b0;
			start_init <= 1'b0;
		end
		else
		begin
			start_init <= 1'b0;
			if (launch)
				pending <= 1'b0;
			if (wr_fire && aw_addr_q == REG_CTRL && w_strb_q[0])
			begin
				ctrl <= {w_data_q[7:1], 1'b0};
				start_init <= w_data_q[CTRL_START_BIT];
			end
			else if (wr_fire && aw_addr_q == REG_ADDR)
			begin
				// Lanes 0 and 1 are full bytes; lane 2 holds only the six top bits
				for (int i = 0; i < 2; i++)
					if (w_strb_q[i])
						addr_reg[8*i+:8] <= w_data_q[8*i+:8];
				addr_reg[21:16] <= w_strb_q[2] ? w_data_q[21:16] : addr_reg[21:16];
			end
			else if (wr_fire && aw_addr_q == REG_STATUS && w_strb_q[0] && w_data_q[ST_DROP_BIT])
				dropped <= 1'b0;
			else if (wr_fire && aw_addr_q == REG_CMD && w_strb_q[0])
			begin
				if (pending || state != ST_READY)
					dropped <= 1'b1;
				else
				begin
					pending <= 1'b1;
					pend_op <= w_data_q[1:0];
					pend_bank <= w_data_q[6:4];
				end
			end
		end
	end

	// Row cycle counters per bank
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_extra <= 8'h0;
			for (int b = 0; b < 8; b++)
				trc_left[b] <= 4'h0;
		end
		else
			for (int b = 0; b < 8; b++)
				if (issue_fire && issue_bank == 3'(b))
				begin
					if (issue_write && prog_cfg == CFG_FOUR)
					begin
						trc_left[b] <= WR_RD_TRC_CFG4 - 4'h1;
						wr_extra[b] <= 1'b1;
					end
					else
					begin
						trc_left[b] <= TRC_CLK[cfg_idx] - 4'h1;
						wr_extra[b] <= 1'b0;
					end
				end
				else if (trc_left[b] != 4'h0)
					trc_left[b] <= trc_left[b] - 4'h1;
	end

	// Sequencer and pin drive; pins idle as a no-operation with address low
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= ST_RESET;
			bus.cmd_n <= CMD_NOP;
			bus.addr <= 19'h0;
			bus.bank <= 3'h0;
			cnt <= 11'h0;
			ref_bank <= 3'h0;
			ph2_q <= 19'h0;
			in_init <= 1'b0;
			init_done <= 1'b0;
			prog_cfg <= CFG_ONE;
			cfg_seen <= 1'b0;
		end
		else
		begin
			bus.cmd_n <= CMD_NOP;
			bus.addr <= 19'h0;
			bus.bank <= 3'h0;
			case (state)
				ST_RESET:
					if (start_init)
					begin
						state <= ST_DUMMY;
						in_init <= 1'b1;
						cnt <= 11'h0;
					end
				ST_DUMMY:
				begin
					bus.cmd_n <= CMD_MRS;
					if (cnt == INIT_DUMMY_MRS)
					begin
						bus.addr <= {9'h0, mode_val};
						state <= ST_WAIT_A;
						cnt <= 11'h0;
					end
					else
						cnt <= cnt + 11'h1;
				end
				ST_WAIT_A, ST_WAIT_B:
					if (cnt == MRSC_CYC - 11'h1)
					begin
						cnt <= 11'h0;
						state <= (state == ST_WAIT_A) ? ST_MRS_PH1
							: (in_init ? ST_REFRESH : ST_READY);
					end
					else
						cnt <= cnt + 11'h1;
				ST_MRS_PH1:
				begin
					bus.cmd_n <= CMD_MRS;
					bus.addr <= {9'h0, mode_val[9:8], 2'h0, mode_val[5:3], 2'h0,
						mode_val[0]};
					state <= ST_MRS_PH2;
				end
				ST_MRS_PH2:
				begin
					bus.addr <= {9'h0, mode_val[7], 4'h0, mode_val[2:1], 3'h0};
					prog_cfg <= ctrl[7:5];
					cfg_seen <= 1'b1;
					state <= ST_WAIT_B;
				end
				ST_REFRESH:
				begin
					bus.cmd_n <= CMD_AUTO_REFRESH_CMD;
					bus.bank <= ref_bank;
					ref_bank <= ref_bank + 3'h1;
					if (ref_bank == LAST_BANK)
						state <= ST_NOPS;
				end
				ST_NOPS:
					if (cnt == INIT_NOP_CNT - 11'h1)
					begin
						state <= ST_READY;
						in_init <= 1'b0;
						init_done <= 1'b1;
						cnt <= 11'h0;
					end
					else
						cnt <= cnt + 11'h1;
				ST_READY:
					if (launch && pend_op == OP_MODE)
						state <= ST_MRS_PH1;
					else if (launch && pend_op == OP_REFRESH)
					begin
						bus.cmd_n <= CMD_AUTO_REFRESH_CMD;
						bus.bank <= pend_bank;
					end
					else if (launch)
					begin
						bus.cmd_n <= (pend_op == OP_WRITE) ? CMD_WRITE : CMD_READ;
						bus.bank <= pend_bank;
						bus.addr <= phase_one(addr_reg, ctrl[2:1], bl_eff);
						ph2_q <= phase_two(addr_reg, ctrl[2:1], bl_eff);
						state <= ST_PHASE2;
					end
				ST_PHASE2:
				begin
					bus.addr <= ph2_q;
					state <= ST_READY;
				end
				default:
					state <= ST_RESET;
			endcase
		end
	end
endmodule : mux_dram_ctrl

// ---- tb/mux_dram_properties.sv ----
// Timing checks on the pin interface and the memory end's outputs
module mux_dram_properties
	import mux_dram_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] cmd_n,
	input wire logic [18:0] addr,
	input wire logic [2:0] bank,
	input wire logic exec_valid,
	input wire logic [1:0] exec_op,
	input wire logic [2:0] exec_bank,
	input wire logic [21:0] exec_addr,
	input wire logic mux_mode,
	input wire logic dll_on,
	input wire logic [3:0] row_cycle_time,
	input wire logic [3:0] read_latency,
	input wire logic [3:0] write_latency
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Decoded pin states; a mode set in mux mode spans two edges
	logic is_rw;
	logic is_mrs;
	assign is_rw = mux_mode && (cmd_n == CMD_READ || cmd_n == CMD_WRITE);
	assign is_mrs = mux_mode && cmd_n == CMD_MRS;

	rw_exec_a: assert property (is_rw |-> ##2 exec_valid && exec_bank == $past(bank, 2)
		&& exec_addr[3] == $past(addr[3], 2) && exec_addr[2:1] == $past(addr[4:3])
		&& exec_addr[7:6] == $past(addr[9:8]))
		else $error("two-phase command not executed as assembled");
	ref_exec_a: assert property (mux_mode && cmd_n == CMD_AUTO_REFRESH_CMD |-> ##2 exec_valid
		&& exec_op == OP_REFRESH && exec_bank == $past(bank, 2))
		else $error("refresh not executed one edge after issue");
	phase_idle_a: assert property (is_rw || is_mrs |=> cmd_n[2])
		else $error("command pins not idle in second phase");
	mode_zero_a: assert property (is_mrs |-> addr[18:10] == 9'h000 ##1 addr[18:10] == 9'h000)
		else $error("upper address balls not zero in mode set");
	mode_a5_a: assert property (is_mrs |-> addr[5])
		else $error("mode set in mux mode without ball five high");
	enter_mux_a: assert property (!mux_mode && cmd_n == CMD_MRS && addr[5] |-> ##[1:2] mux_mode)
		else $error("mode set with ball five high did not enter mux mode");
	recovery_a: assert property ($rose(mux_mode) |-> (cmd_n != CMD_MRS) [*5])
		else $error("mode set issued inside recovery time");
	dll_off_a: assert property (is_mrs ##1 addr[9] |-> ##[1:2] !dll_on)
		else $error("delay loop still on after its reset field");
	mux_lat_a: assert property ((mux_mode && $stable(row_cycle_time)) [*3] |->
		read_latency == row_cycle_time + 4'h1 && write_latency == row_cycle_time + 4'h2)
		else $error("mux latencies not one above the table pair");
	plain_lat_a: assert property ((!mux_mode && $stable(row_cycle_time)) [*3] |->
		read_latency == row_cycle_time)
		else $error("non-mux read latency wrong");

	// Main traffic kinds seen at least once
	cover property (is_mrs ##1 addr[9]);
	cover property (mux_mode && cmd_n == CMD_AUTO_REFRESH_CMD ##1 cmd_n == CMD_AUTO_REFRESH_CMD);
	cover property (is_rw ##2 exec_valid);
endmodule : mux_dram_properties

// ---- tb/muxed_address_dram_interface_tb.sv ----
// Bench joining controller and memory end; driven over AXI4-Lite
module muxed_address_dram_interface_tb
	import mux_dram_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn;
	logic [1:0] org;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic exec_valid, mux_mode, dll_on;
	logic [1:0] exec_op, ev_op;
	logic [2:0] exec_bank, ev_bank;
	logic [21:0] exec_addr, ev_addr;
	logic [9:0] mode_word;
	logic [3:0] row_cycle_time, read_latency, write_latency;
	logic [7:0] refreshed;
	int cyc, ev_cnt, ev_time, error_cnt, checks_done;

	mux_dram_if link();
	mux_dram_ctrl i_mux_dram_ctrl (.aclk, .aresetn, .bus(link), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	mux_dram_dev i_mux_dram_dev (.aclk, .aresetn, .bus(link), .org, .exec_valid, .exec_op,
		.exec_bank, .exec_addr, .mux_mode, .dll_on, .mode_word, .row_cycle_time, .read_latency,
		.write_latency);
	mux_dram_properties i_mux_dram_properties (.aclk, .aresetn, .cmd_n(link.cmd_n),
		.addr(link.addr), .bank(link.bank), .exec_valid, .exec_op, .exec_bank, .exec_addr,
		.mux_mode, .dll_on, .row_cycle_time, .read_latency, .write_latency);

	// Clock at 10 MHz
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Log executed commands; refreshes mark their bank
	always @(posedge aclk)
	begin
		cyc++;
		if (exec_valid === 1'b1)
		begin
			ev_cnt++;
			ev_time = cyc;
			ev_op = exec_op;
			ev_bank = exec_bank;
			ev_addr = exec_addr;
			if (exec_op === OP_REFRESH)
				refreshed[exec_bank] = 1'b1;
		end
	end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// AXI write: both halves offered together, each released when taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 100);
		check(s_axi_bvalid, 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	// AXI read; rready held until the data edge
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1 && n < 100);
		check(s_axi_rvalid, 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// Poll status until init done and not busy; bounded
	task automatic wait_ready;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		n = 0;
		do
		begin
			axi_rd(REG_STATUS, d, r);
			n++;
		end
		while (d[1:0] !== 2'h2 && n < 1000);
		check(d[1:0], 2'h2);
	endtask : wait_ready

	// Launch one command and wait for its execution
	task automatic run_cmd(input logic [1:0] op, input logic [2:0] bk);
		logic [1:0] r;
		int c0, n;
		c0 = ev_cnt;
		n = 0;
		axi_wr(REG_CMD, {25'h0, bk, 2'h0, op}, r);
		while (ev_cnt == c0 && n < 50)
		begin
			@(posedge aclk);
			n++;
		end
		check(ev_cnt != c0, 1'b1);
	endtask : run_cmd

	// Expected rebuilt address for an all-ones request; no burst of eight is used
	function automatic logic [21:0] exp_addr(input logic [1:0] o, input logic [1:0] b);
		logic [21:0] a;
		a = 22'h07FFFF;
		a[19] = !(o == ORG_X36 && b != BL_2);
		a[20] = (o == ORG_X18 && b == BL_2) || (o == ORG_X9 && b != BL_8);
		a[21] = o == ORG_X9 && b == BL_2;
		return a;
	endfunction : exp_addr

	// Reset for three cycles with a new width strap
	task automatic do_reset(input logic [1:0] o);
		@(posedge aclk);
		aresetn <= 1'b0;
		org <= o;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		refreshed = 8'h00;
	endtask : do_reset

	// Init, table values, address folding and same-bank spacing for one setup
	task automatic test_combo(input logic [1:0] o, input logic [1:0] b, input logic [2:0] c);
		logic [1:0] r;
		int t0;
		do_reset(o);
		axi_wr(REG_CTRL, {24'h0, c, b, o, 1'b1}, r);
		wait_ready;
		check(mux_mode, 1'b1);
		check(refreshed, 8'hFF);
		check(row_cycle_time, TRC_CLK[c]);
		check(read_latency, RL_CLK[c]);
		check(write_latency, WL_CLK[c]);
		axi_wr(REG_ADDR, 32'h003FFFFF, r);
		run_cmd(OP_WRITE, 3'h5);
		check(ev_addr, exp_addr(o, b));
		check({ev_op, ev_bank}, {OP_WRITE, 3'h5});
		t0 = ev_time;
		run_cmd(OP_READ, 3'h5);
		check(ev_time - t0 >= ((c == CFG_FOUR) ? WR_RD_TRC_CFG4 : TRC_CLK[c]), 1'b1);
		run_cmd(OP_REFRESH, 3'h2);
		check({ev_op, ev_bank}, {OP_REFRESH, 3'h2});
		$display("combo %0d %0d %0d done", o, b, c);
	endtask : test_combo

	// Unaligned places answer with an error and change nothing
	task automatic test_bus;
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(4'h2, 32'hFFFFFFFF, r);
		check(r, RESP_SLVERR);
		axi_rd(4'h6, d, r);
		check(r, RESP_SLVERR);
		check(d, 32'h0);
		wait_ready;
		$display("bus test done");
	endtask : test_bus

	// New configuration resets the delay loop; a repeat turns it on again
	task automatic test_dll(input logic [1:0] o, input logic [1:0] b, input logic [2:0] c);
		logic [1:0] r;
		axi_wr(REG_CTRL, {24'h0, c, b, o, 1'b0}, r);
		axi_wr(REG_CMD, {30'h0, OP_MODE}, r);
		wait_ready;
		check(dll_on, 1'b0);
		check(row_cycle_time, TRC_CLK[c]);
		axi_wr(REG_CMD, {30'h0, OP_MODE}, r);
		wait_ready;
		check(dll_on, 1'b1);
		$display("delay loop test done");
	endtask : test_dll

	// Verdict and end of run
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	// Main sequence: six width, burst and configuration setups
	initial
	begin
		aresetn = 1'b0;
		org = 2'h0;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		for (int i = 0; i < 6; i++)
		begin
			test_combo(2'(i / 2), 2'(i % 2), 3'(i % 5));
			if (i == 0)
				test_bus;
		end
		test_dll(ORG_X9, BL_4, 3'h1);
		finish_test;
	end

	// Watchdog well beyond six inits of about 1,100 cycles
	initial
	begin
		repeat (40000) @(posedge aclk);
		error_cnt++;
		finish_test;
	end
endmodule : muxed_address_dram_interface_tb
